// ### bus_retry_fault_pkg.sv
// Shared constants and types for the bus retry, fault and serializer block.
// Assumes a single 200 MHz bus clock and an external cycle terminator.
`default_nettype none

package bus_retry_fault_pkg;

   localparam int          ADDR_W            = 32;
   localparam int          DATA_W            = 32;
   localparam int          WQ_DEPTH          = 4;
   localparam logic [3:0]  PSC_RUN           = 4'h0;
   localparam logic [3:0]  PSC_DOUBLE_FAULT  = 4'h5;
   localparam logic [1:0]  LINE_FIRST_BEAT   = 2'h0;
   localparam logic [1:0]  LINE_LAST_BEAT    = 2'h3;
   localparam logic [1:0]  TERM_IDLE         = 2'h3;
   localparam logic [2:0]  PIN_RESET         = 3'h7;

   // One bus access with all of its transfer attributes.
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
      logic              write;
      logic              lock;
      logic              lock_last;
      logic              line;
      logic              burst_inh;
      logic              nc_io;
   } bus_req_t;

   typedef enum logic [2:0] {
      S_IDLE  = 3'b000,
      S_ARB   = 3'b001,
      S_START = 3'b010,
      S_WAIT  = 3'b011,
      S_HALT  = 3'b100
   } bus_state_t;

endpackage

`default_nettype wire

// ### bus_retry_fault_serializer.sv
// Bus exception and access ordering logic of a 32-bit processor.
// Assumes external logic terminates cycles and an arbiter grants the bus;
// pin inputs are asynchronous and are filtered through four flip-flops.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [RULE1] Both acknowledges asserted: end the cycle and reissue it unchanged.
// [RULE2] Locked read and write are retried one by one, lock held throughout.
// [RULE3] Retried last locked cycle keeps lock-end asserted until write completes.
// [RULE4] Retry on the first transfer of a line repeats that cycle normally.
// [RULE5] Retry on a later line transfer is a bus error and aborts the line.
// [RULE6] Burst-inhibited lines retry only the first transfer, else abort.
// [RULE7] Retry with grant removed: release the bus, rerun the cycle later.
// [RULE8] Error during exception processing of an earlier fault is double fault.
// [RULE9] After double fault, status output shows code 5 until reset.
// [RULE10] Only external reset leaves the halted state.
// [RULE11] While halted, bus request is negated and all outputs float.
// [RULE12] Errors after exception processing are ordinary, never double faults.
// [RULE13] Retries are not errors; repeat the cycle as long as retries come.
// [RULE14] Operand reads take priority over pending writeback writes.
// [RULE15] A read hitting a pending write waits until that write completes.
// [RULE16] Reads stay in order, writes stay in order; reads may pass writes.
// [RULE17] Noncachable I/O read first drains all pending writes.
// [RULE18] Noncachable I/O attribute changes read handling only.
// [RULE19] A started noncachable I/O read ends only by completion or bus error.
// [RULE20] Synchronizing instruction stalls until every bus cycle is finished.
// [RULE21] A write hitting the enabled data cache updates the line at once.
// [RULE22] System asserts and negates both acknowledges on the same edge.
// [RULE23] Error acknowledge without normal acknowledge is a bus error.
// [RULE24] Retried cycle restarts on the first owned clock, with transfer start.
module bus_retry_fault_serializer #(
   parameter int WQ_DEPTH = bus_retry_fault_pkg::WQ_DEPTH
) (
   input  wire logic                          clk_i,               // bus clock
   input  wire logic                          rst_n_i,             // sync reset
   input  wire bus_retry_fault_pkg::bus_req_t rd_req_i,            // read access
   input  wire logic                          rd_valid_i,          // read wanted
   input  wire bus_retry_fault_pkg::bus_req_t wr_req_i,            // write access
   input  wire logic                          wr_valid_i,          // write offered
   input  wire logic                          wr_cache_hit_i,      // write hits
   input  wire logic                          dcache_en_i,         // cache enabled
   input  wire logic                          sync_req_i,          // sync insn
   input  wire logic                          exc_stacking_i,      // in exception
   input  wire logic                          addr_err_i,          // address error
   input  wire logic [31:0]                   data_i,              // bus data in
   input  wire logic                          transfer_ack_n_i,    // normal ack
   input  wire logic                          transfer_error_ack_n_i, // error ack
   input  wire logic                          bus_grant_n_i,       // bus granted
   output logic                               wr_ready_o,          // queue room
   output logic                               cache_upd_o,         // line update
   output logic                               rd_done_o,           // read beat
   output logic                               rd_last_o,           // final beat
   output logic                               rd_err_o,            // read errored
   output logic [31:0]                        rd_data_o,           // read data
   output logic                               access_err_o,        // bus error
   output logic                               sync_stall_o,        // stall core
   output logic                               ts_n_o,              // start
   output logic [31:0]                        addr_o,              // address
   output logic [31:0]                        data_o,              // write data
   output logic                               write_o,             // 1 = write
   output logic [1:0]                         beat_o,              // line beat
   output logic                               lock_n_o,            // locked
   output logic                               locked_seq_last_n_o, // lock end
   output logic                               bus_request_n_o,     // request
   output logic                               bus_oe_n_o,          // pins driven
   output logic [3:0]                         proc_status_code_o   // status
);

   localparam int PTR_W = (WQ_DEPTH > 1) ? $clog2(WQ_DEPTH) : 1;
   localparam int CNT_W = $clog2(WQ_DEPTH + 1);

   bus_retry_fault_pkg::bus_state_t state;
   bus_retry_fault_pkg::bus_state_t next_state;
   bus_retry_fault_pkg::bus_req_t   cur;
   bus_retry_fault_pkg::bus_req_t   wq [WQ_DEPTH];

   logic [2:0]       pin_s1;
   logic [2:0]       pin_s2;
   logic [2:0]       pin_s3;
   logic [2:0]       pin_f;
   logic [1:0]       term_q;
   logic [1:0]       beat;
   logic [PTR_W-1:0] wq_head;
   logic [PTR_W-1:0] wq_tail;
   logic [CNT_W-1:0] wq_count;
   logic [CNT_W-1:0] next_wq_count;
   logic [WQ_DEPTH-1:0] hit_vec;
   logic             term_seen;
   logic             t_ok;
   logic             t_retry;
   logic             t_err;
   logic             granted;
   logic             rd_collide;
   logic             take_read;
   logic             take_write;
   logic             wr_push;
   logic             cyc_end;
   logic             bus_fault;
   logic             double_fault;
   logic             line_more;

   // The pins are asynchronous; a level is taken only once the second and
   // third stages agree, which costs latency but rejects runt glitches.
   genvar g;
   generate
      for (g = 0; g < 3; g++)
      begin : g_pin_sync
         always_ff @(posedge clk_i)
         begin
            if (!rst_n_i)
            begin
               pin_s1[g] <= 1'b1;
               pin_s2[g] <= 1'b1;
               pin_s3[g] <= 1'b1;
               pin_f[g]  <= 1'b1;
            end
            else
            begin
               pin_s1[g] <= (g == 2) ? transfer_ack_n_i :
                            (g == 1) ? transfer_error_ack_n_i : bus_grant_n_i;
               pin_s2[g] <= pin_s1[g];
               pin_s3[g] <= pin_s2[g];
               if (pin_s2[g] == pin_s3[g])
                  pin_f[g] <= pin_s3[g];
            end
         end
      end
   endgenerate

   // Termination is taken once, when the acknowledge pair leaves idle.
   assign term_seen = (state == bus_retry_fault_pkg::S_WAIT) &&
                      (term_q == bus_retry_fault_pkg::TERM_IDLE) &&
                      (pin_f[2:1] != bus_retry_fault_pkg::TERM_IDLE); // see [RULE22]
   assign t_retry   = term_seen && !pin_f[2] && !pin_f[1];          // see [RULE1]
   assign t_ok      = term_seen && !pin_f[2] && pin_f[1];
   assign t_err     = term_seen && pin_f[2] && !pin_f[1];           // see [RULE23]
   assign granted   = !pin_f[0];
   assign line_more = cur.line && (beat != bus_retry_fault_pkg::LINE_LAST_BEAT);

   // A retry past the first line beat counts as a bus error.
   assign bus_fault = t_err || (t_retry && cur.line &&
                      (beat != bus_retry_fault_pkg::LINE_FIRST_BEAT)); // see [RULE5] see [RULE6]
   assign cyc_end   = (t_ok && !line_more) || bus_fault;
   assign double_fault = exc_stacking_i && (bus_fault || addr_err_i); // see [RULE8] see [RULE12]

   // Address collision against every queued write.
   generate
      for (g = 0; g < WQ_DEPTH; g++)
      begin : g_collide
         assign hit_vec[g] = (PTR_W'(g - int'(wq_head)) < PTR_W'(wq_count)
                              || wq_count == CNT_W'(WQ_DEPTH)) &&
                             (wq[g].addr[31:2] == rd_req_i.addr[31:2]);
      end
   endgenerate
   assign rd_collide = |hit_vec; // see [RULE15]

   // Reads go first unless they collide or target an I/O page with writes
   // still queued; the attribute is never looked at for writes.
   assign take_read  = rd_valid_i && !rd_done_o && !rd_collide &&
                       !(rd_req_i.nc_io && wq_count != '0); // see [RULE14] see [RULE17] see [RULE18]
   assign take_write = !take_read && wq_count != '0; // see [RULE16]

   always_comb
   begin
      next_state = state;
      case (state)
         bus_retry_fault_pkg::S_IDLE:
            // The access is loaded here, a cycle ahead of its start, so the
            // start cycle drives its own attributes rather than stale ones.
            if (take_read || take_write)
               next_state = bus_retry_fault_pkg::S_ARB;
         bus_retry_fault_pkg::S_ARB:
            if (granted)
               next_state = bus_retry_fault_pkg::S_START;
         bus_retry_fault_pkg::S_START:
            next_state = bus_retry_fault_pkg::S_WAIT;
         bus_retry_fault_pkg::S_WAIT:
            if (cyc_end)
               next_state = bus_retry_fault_pkg::S_IDLE;
            else if (t_retry)
               next_state = granted ? bus_retry_fault_pkg::S_START
                                    : bus_retry_fault_pkg::S_ARB; // see [RULE7] see [RULE24]
            else if (t_ok && cur.burst_inh)
               next_state = bus_retry_fault_pkg::S_START;
         default:
            next_state = bus_retry_fault_pkg::S_HALT;
      endcase
      if (double_fault)
         next_state = bus_retry_fault_pkg::S_HALT;
      if (state == bus_retry_fault_pkg::S_HALT)
         next_state = bus_retry_fault_pkg::S_HALT; // see [RULE10]
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         state  <= bus_retry_fault_pkg::S_IDLE;
         term_q <= bus_retry_fault_pkg::TERM_IDLE;
      end
      else
      begin
         state  <= next_state;
         term_q <= pin_f[2:1];
      end
   end

   // The access stays loaded across retries so every repeat is identical.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         cur  <= '0;
         beat <= bus_retry_fault_pkg::LINE_FIRST_BEAT;
      end
      else if (state == bus_retry_fault_pkg::S_IDLE)
      begin
         beat <= bus_retry_fault_pkg::LINE_FIRST_BEAT;
         if (take_read)
            cur <= rd_req_i;
         else if (take_write)
            cur <= wq[wq_head];
      end
      else if (t_ok && line_more)
         beat <= beat + 2'h1; // see [RULE4] see [RULE13]
   end

   // Write queue; entries leave strictly in arrival order.
   assign wr_push = wr_valid_i && wr_ready_o;
   always_comb
   begin
      next_wq_count = wq_count;
      if (wr_push)
         next_wq_count = next_wq_count + CNT_W'(1);
      if (cyc_end && cur.write && state == bus_retry_fault_pkg::S_WAIT)
         next_wq_count = next_wq_count - CNT_W'(1);
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         wq_head    <= '0;
         wq_tail    <= '0;
         wq_count   <= '0;
         wr_ready_o <= 1'b1;
      end
      else
      begin
         wq_count   <= next_wq_count;
         wr_ready_o <= next_wq_count < CNT_W'(WQ_DEPTH);
         if (wr_push)
         begin
            wq[wq_tail] <= wr_req_i;
            wq_tail     <= (wq_tail == PTR_W'(WQ_DEPTH - 1)) ? '0
                                                           : wq_tail + PTR_W'(1);
         end
         if (cyc_end && cur.write)
            wq_head <= (wq_head == PTR_W'(WQ_DEPTH - 1)) ? '0
                                                       : wq_head + PTR_W'(1);
      end
   end

   // The cache line is written when the write enters the queue.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         cache_upd_o <= 1'b0;
      else
         cache_upd_o <= wr_push && wr_cache_hit_i && dcache_en_i; // see [RULE21]
   end

   // Core-side answers; a started read runs to its own end unless a double fault halts the block.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         rd_done_o    <= 1'b0;
         rd_last_o    <= 1'b0;
         rd_err_o     <= 1'b0;
         rd_data_o    <= '0;
         access_err_o <= 1'b0;
      end
      else
      begin
         rd_done_o    <= !cur.write && (t_ok || bus_fault) && !double_fault; // see [RULE19]
         rd_last_o    <= !cur.write && cyc_end;
         rd_err_o     <= !cur.write && bus_fault;
         rd_data_o    <= data_i;
         access_err_o <= (bus_fault || addr_err_i) && !exc_stacking_i; // see [RULE12] see [RULE13]
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         sync_stall_o <= 1'b0;
      else
         sync_stall_o <= sync_req_i &&
                         (next_wq_count != '0 || rd_valid_i ||
                          next_state != bus_retry_fault_pkg::S_IDLE); // see [RULE20]
   end

   // Bus pins; every drive is dropped and the request negated on halt.
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         ts_n_o              <= 1'b1;
         addr_o              <= '0;
         data_o              <= '0;
         write_o             <= 1'b0;
         beat_o              <= '0;
         lock_n_o            <= 1'b1;
         locked_seq_last_n_o <= 1'b1;
         bus_request_n_o     <= 1'b1;
         bus_oe_n_o          <= 1'b1;
         proc_status_code_o  <= bus_retry_fault_pkg::PSC_RUN;
      end
      else if (next_state == bus_retry_fault_pkg::S_HALT)
      begin
         ts_n_o              <= 1'b1;
         lock_n_o            <= 1'b1;
         locked_seq_last_n_o <= 1'b1;
         bus_request_n_o     <= 1'b1; // see [RULE11]
         bus_oe_n_o          <= 1'b1;
         proc_status_code_o  <= bus_retry_fault_pkg::PSC_DOUBLE_FAULT; // see [RULE9]
      end
      else
      begin
         ts_n_o  <= next_state != bus_retry_fault_pkg::S_START; // see [RULE24]
         addr_o  <= {cur.addr[31:4], cur.line ? beat : cur.addr[3:2],
                     cur.addr[1:0]};
         data_o  <= cur.data;
         write_o <= cur.write;
         beat_o  <= beat;
         // Lock signals follow the loaded access, so a retry leaves them set.
         lock_n_o <= !(cur.lock && state != bus_retry_fault_pkg::S_IDLE); // see [RULE2]
         locked_seq_last_n_o <= !(cur.lock && cur.lock_last && cur.write &&
                                  state != bus_retry_fault_pkg::S_IDLE &&
                                  !cyc_end); // see [RULE3]
         bus_request_n_o <= !(next_state == bus_retry_fault_pkg::S_ARB ||
                              next_state == bus_retry_fault_pkg::S_START ||
                              next_wq_count != '0 || rd_valid_i); // see [RULE7]
         bus_oe_n_o <= !(granted || state == bus_retry_fault_pkg::S_WAIT);
         proc_status_code_o <= bus_retry_fault_pkg::PSC_RUN;
      end
   end

endmodule // bus_retry_fault_serializer

`default_nettype wire

// ### bus_retry_fault_props.sv
// Concurrent checks on the top ports of the bus retry and fault block.
// Bound to every instance of the top; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module bus_retry_fault_props (
   input wire logic       clk_i,                  // bus clock
   input wire logic       rst_n_i,                // sync reset
   input wire logic       exc_stacking_i,         // in exception
   input wire logic       addr_err_i,             // address error
   input wire logic       transfer_ack_n_i,       // normal ack
   input wire logic       transfer_error_ack_n_i, // error ack
   input wire logic       bus_grant_n_i,          // grant
   input wire logic       ts_n_o,                 // start
   input wire logic [1:0] beat_o,                 // line beat
   input wire logic       lock_n_o,               // locked
   input wire logic       bus_request_n_o,        // request
   input wire logic       bus_oe_n_o,             // float
   input wire logic       access_err_o,           // bus error
   input wire logic [3:0] proc_status_code_o      // status
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // Retry seen on the pins for a first beat; later beats count as errors.
   wire retry = !transfer_ack_n_i && !transfer_error_ack_n_i
      && beat_o == bus_retry_fault_pkg::LINE_FIRST_BEAT;
   wire halted =
      proc_status_code_o == bus_retry_fault_pkg::PSC_DOUBLE_FAULT;

   AST_HALT_HOLD: assert property (halted |=> halted)
      else $error("double fault status dropped without reset");
   AST_HALT_FLOAT: assert property (
      halted |-> bus_request_n_o && bus_oe_n_o && ts_n_o)
      else $error("halted block still drives the bus");
   AST_DFAULT: assert property (
      addr_err_i && exc_stacking_i |=> halted)
      else $error("error during exception processing did not halt");
   AST_NO_DFAULT: assert property (
      addr_err_i && !exc_stacking_i && !halted |=> !halted)
      else $error("ordinary address error halted the block");
   AST_TS_PULSE: assert property (!ts_n_o |=> ts_n_o)
      else $error("transfer start held longer than one cycle");
   AST_RETRY_TS: assert property (
      retry && !bus_grant_n_i && !halted |-> ##[2:10] !ts_n_o)
      else $error("retried cycle was not restarted");
   AST_RELINQUISH: assert property (
      retry && bus_grant_n_i |=> ts_n_o [*6])
      else $error("retry started without bus grant");
   AST_LOCK_HELD: assert property (
      retry && !lock_n_o |=> !lock_n_o [*8])
      else $error("lock released during retry");
   AST_RETRY_NO_ERR: assert property (
      retry |=> !access_err_o [*8])
      else $error("retry reported as bus error");

   cover property (retry && !lock_n_o);
   cover property (retry && bus_grant_n_i);
   cover property (halted);
endmodule // bus_retry_fault_props

bind bus_retry_fault_serializer bus_retry_fault_props u_props (
   .clk_i, .rst_n_i, .exc_stacking_i, .addr_err_i, .transfer_ack_n_i,
   .transfer_error_ack_n_i, .bus_grant_n_i, .ts_n_o, .beat_o, .lock_n_o,
   .bus_request_n_o, .bus_oe_n_o, .access_err_o, .proc_status_code_o);
`default_nettype wire

// ### bus_term_model.sv
// Behavioural cycle terminator and arbiter on the far side of the block.
// Assumes pulled-up active-low pins; plan entries are 2 bits per cycle.
`timescale 1ns/1ps
`default_nettype none
module bus_term_model (
   input  wire logic        clk_i,    // bus clock
   input  wire logic        ts_n_i,   // transfer start
   input  wire logic        load_i,   // take a new plan
   input  wire logic [15:0] plan_i,   // 0 ok 1 error 2 retry 3 relinquish
   output logic             ack_n_o,  // normal ack
   output logic             err_n_o,  // error ack
   output logic             grant_n_o // bus grant
);
   logic [15:0] pl = '0;
   logic [1:0]  k;
   initial ack_n_o = 1'b1;
   initial err_n_o = 1'b1;
   initial grant_n_o = 1'b0;
   always @(posedge clk_i)
      if (load_i)
         pl = plan_i;
   // Pins are held two cycles so the block's input filter accepts them.
   always
   begin
      @(posedge clk_i iff ts_n_i === 1'b0);
      repeat (2) @(posedge clk_i);
      #1;
      k = pl[1:0];
      pl = pl >> 2;
      ack_n_o = (k == 2'h1);
      err_n_o = (k == 2'h0);
      grant_n_o = &k;
      repeat (2) @(posedge clk_i);
      #1;
      ack_n_o = 1'b1;
      err_n_o = 1'b1;
      if (k == 2'h3)
      begin
         repeat (8) @(posedge clk_i);
         #1;
         grant_n_o = 1'b0;
      end
   end
endmodule // bus_term_model
`default_nettype wire

// ### bus_retry_fault_serializer_bench.sv
// Self-checking bench for the bus retry, fault and serializer block.
// Uses the far-side model for acks and grant; one clock at 200 MHz.
`timescale 1ns/1ps
`default_nettype none
module bus_retry_fault_serializer_bench;
   localparam logic [31:0] DPAT = 32'hA5C3_1E7F;
   logic clk_i = 1'b0, rst_n_i = 1'b0, load = 1'b0;
   bus_retry_fault_pkg::bus_req_t rd_req_i = '0, wr_req_i = '0;
   logic rd_valid_i = 1'b0, wr_valid_i = 1'b0, wr_cache_hit_i = 1'b0;
   logic dcache_en_i = 1'b1, sync_req_i = 1'b0, exc_stacking_i = 1'b0;
   logic addr_err_i = 1'b0;
   logic [31:0] data_i = DPAT;
   logic [15:0] plan = '0;
   wire logic transfer_ack_n_i, transfer_error_ack_n_i, bus_grant_n_i;
   logic cache_upd_o, rd_done_o, rd_last_o, rd_err_o, sync_stall_o;
   logic ts_n_o, write_o, bus_request_n_o, bus_oe_n_o;
   logic [31:0] rd_data_o, addr_o, data_o, rd_addr, wr_data;
   logic wr_ready_o, locked_seq_last_n_o, lk_end;
   logic [3:0] proc_status_code_o;
   int n_errors = 0, total_checks = 0, n_ts = 0, rd_pos = 0;

   always #2.5 clk_i = ~clk_i;

   bus_retry_fault_serializer dut (.clk_i, .rst_n_i, .rd_req_i, .rd_valid_i,
      .wr_req_i, .wr_valid_i, .wr_cache_hit_i, .dcache_en_i, .sync_req_i,
      .exc_stacking_i, .addr_err_i, .data_i, .transfer_ack_n_i,
      .transfer_error_ack_n_i, .bus_grant_n_i, .wr_ready_o, .cache_upd_o,
      .rd_done_o, .rd_last_o, .rd_err_o, .rd_data_o, .access_err_o(),
      .sync_stall_o, .ts_n_o, .addr_o, .data_o, .write_o, .beat_o(),
      .lock_n_o(), .locked_seq_last_n_o, .bus_request_n_o, .bus_oe_n_o,
      .proc_status_code_o);
   bus_term_model far (.clk_i, .ts_n_i(ts_n_o), .load_i(load),
      .plan_i(plan), .ack_n_o(transfer_ack_n_i),
      .err_n_o(transfer_error_ack_n_i), .grant_n_o(bus_grant_n_i));

   // Counts bus starts and notes the position of the read among them.
   always @(posedge clk_i)
      if (ts_n_o === 1'b0)
      begin
         if (write_o === 1'b0)
         begin
            rd_pos = n_ts;
            rd_addr = addr_o;
         end
         else
         begin
            wr_data = data_o;
            lk_end = locked_seq_last_n_o;
         end
         n_ts++;
      end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   task automatic go(input logic [15:0] p);
      plan = p;
      load = 1'b1;
      tick(1);
      load = 1'b0;
      n_ts = 0;
      rd_pos = 9;
   endtask

   // f holds line (burst inhibited), lock and noncachable I/O.
   task automatic do_read(input logic [31:0] a, input logic [2:0] f,
                          output int b, output logic e);
      rd_req_i = '0;
      rd_req_i.addr = a;
      {rd_req_i.line, rd_req_i.lock, rd_req_i.nc_io} = f;
      rd_req_i.burst_inh = f[2];
      rd_valid_i = 1'b1;
      b = 0;
      e = 1'b0;
      for (int t = 0; t < 300 && rd_valid_i; t++)
      begin
         tick(1);
         if (rd_done_o === 1'b1)
         begin
            b++;
            e |= rd_err_o;
            if (rd_err_o === 1'b0)
               check(rd_data_o, DPAT);
            if (rd_last_o === 1'b1)
               rd_valid_i = 1'b0;
         end
      end
      rd_valid_i = 1'b0;
   endtask

   // f holds cache hit, noncachable I/O, lock and lock end.
   task automatic do_write(input logic [31:0] a, input logic [3:0] f);
      wr_req_i = '0;
      wr_req_i.addr = a;
      wr_req_i.write = 1'b1;
      wr_req_i.data = ~a;
      {wr_req_i.nc_io, wr_req_i.lock, wr_req_i.lock_last} = f[2:0];
      wr_cache_hit_i = f[3];
      wr_valid_i = 1'b1;
      tick(1);
      wr_valid_i = 1'b0;
      check({cache_upd_o, wr_ready_o}, {f[3] & dcache_en_i, 1'b1});
   endtask

   task automatic drain(input logic busy, input bit chk);
      sync_req_i = 1'b1;
      tick(2);
      if (chk)
         check(sync_stall_o, busy);
      for (int t = 0; t < 400 && sync_stall_o !== 1'b0; t++)
         tick(1);
      check(sync_stall_o, 1'b0);
      sync_req_i = 1'b0;
      tick(1);
   endtask

   task automatic t_single;
      int b;
      logic e;
      logic [15:0] pl [4] = '{16'h0000, 16'h0001, 16'h002A, 16'h0003};
      int nt [4] = '{1, 1, 4, 2};
      for (int i = 0; i < 4; i++)
      begin
         go(pl[i]);
         do_read(32'h0000_0100, 3'h0, b, e);
         check(e, i == 1);
         check(n_ts, nt[i]);
         check(rd_addr, 32'h0000_0100);
      end
   endtask

   task automatic t_line;
      int b;
      logic e;
      go(16'h0002);
      do_read(32'h0000_0200, 3'h4, b, e);
      check(b, 4);
      check({e, n_ts[3:0]}, 5'h05);
      go(16'h0008);
      do_read(32'h0000_0200, 3'h4, b, e);
      check({e, b[3:0]}, 5'h12);
   endtask

   task automatic t_lock;
      int b;
      logic e;
      go(16'h0022);
      do_read(32'h0000_0300, 3'h2, b, e);
      check(e, 1'b0);
      do_write(32'h0000_0300, 4'h3);
      drain(1'b1, 1'b1);
      check(n_ts, 4);
      check(wr_data, ~32'h0000_0300);
      check(lk_end, 1'b0);
   endtask

   // Collision, noncachable I/O read, then a read free to pass writes.
   task automatic t_order;
      int b;
      logic e;
      for (int i = 0; i < 3; i++)
      begin
         go(16'h0000);
         dcache_en_i = (i != 2);
         do_write(32'h0000_0400, 4'h8);
         tick(1);
         do_write(32'h0000_0500, {1'b0, i == 1, 2'b00});
         do_read(i == 0 ? 32'h0000_0500 : 32'h0000_0600,
                 {2'b00, i == 1}, b, e);
         check(rd_pos == 2, i < 2);
         drain(1'b0, 1'b0);
      end
   endtask

   task automatic t_fault;
      int b;
      logic e;
      addr_err_i = 1'b1;
      tick(1);
      addr_err_i = 1'b0;
      tick(2);
      check(proc_status_code_o, bus_retry_fault_pkg::PSC_RUN);
      for (int i = 0; i < 2; i++)
      begin
         exc_stacking_i = 1'b1;
         go(16'h0001);
         addr_err_i = (i == 0);
         tick(1);
         addr_err_i = 1'b0;
         if (i == 1)
            do_read(32'h0000_0700, 3'h0, b, e);
         exc_stacking_i = 1'b0;
         tick(20);
         check(proc_status_code_o, 4'h5);
         check({bus_request_n_o, bus_oe_n_o}, 2'h3);
         rst_n_i = 1'b0;
         tick(10);
         rst_n_i = 1'b1;
         tick(1);
         check(proc_status_code_o, bus_retry_fault_pkg::PSC_RUN);
      end
   endtask

   initial
   begin
      #200000;
      n_errors++;
      complete_run;
   end

   initial
   begin
      tick(10);
      rst_n_i = 1'b1;
      tick(1);
      t_single;
      t_line;
      t_lock;
      t_order;
      t_fault;
      complete_run;
   end
endmodule // bus_retry_fault_serializer_bench
`default_nettype wire
